// file: src/wwdt_top.sv
// Windowed watchdog timer with classic Wishbone register slave.
// Assumes core strobes arrive on clk_in; the RC oscillator arrives as a raw pin.
//
// Behaviour
// - Counter runs from RC oscillator; enable powers it
// - Prescaler divides by 32 or 128
// - Postscaler 4-bit select, 1:1 to 1:32768
// - Any device reset clears all counts
// - Clock switch completion clears all counts
// - Entering sleep or idle clears all counts
// - Leaving sleep or idle clears all counts
// - Clear instruction clears counts; software repeats it
// - Counting continues in sleep and idle
// - Timeout in sleep or idle wakes core
// - Hard enable forces watchdog on
// - Otherwise soft enable bit gates watchdog
// - Device reset clears soft enable
// - Timeout flag sticky until software clears
// - Window disable zero selects windowed mode
`timescale 1ns/1ns
`default_nettype none
`include "wwdt_params.svh"

module wwdt_top (
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	input  wire logic        low_power_rc_osc_in,
	input  wire logic        wd_clear_instr_in,
	input  wire logic        power_save_instr_in,
	input  wire logic        power_save_idle_in,
	input  wire logic        wake_event_in,
	input  wire logic        clk_switch_done_in,
	input  wire logic        sys_reset_in,
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [31:0] wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	output logic             irq_out,
	output logic             low_power_rc_osc_en_out,
	output logic             device_reset_out,
	output logic             wake_out,
	output wwdt_pkg::wwdt_pm_t power_mode_out
);
	import wwdt_pkg::*;

	wwdt_state_t q;
	wwdt_state_t d;

	logic        enabled;
	logic        osc_tick;
	logic [6:0]  pre_last;
	logic [16:0] period;
	logic [15:0] post_last;
	logic [16:0] closed;
	logic        run;
	logic        timeout;
	logic        clr_hit;
	logic        fault;
	logic        dev_rst;
	logic        zero_cnt;
	logic        bus_req;
	logic        wr_lo;
	logic        wr_hi;
	logic        rd_stat;
	logic [2:0]  ev;

	// ********************
	// Derived terms
	// ********************
	assign enabled  = q.cfg[`WWDT_CF_HARD_EN] | q.soft_en;
	assign osc_tick = q.osc_s2 & ~q.osc_s3;
	assign pre_last = q.cfg[`WWDT_CF_PRE] ? `WWDT_PRE_LAST7 : `WWDT_PRE_LAST5;
	assign period   = 17'h0_0001 << q.cfg[`WWDT_CF_POST_HI:`WWDT_CF_POST_LO];
	assign post_last = 16'(period - 17'h0_0001);
	assign run      = (q.pm == WWDT_RUN);
	assign bus_req  = wb_cyc_in & wb_stb_in & ~q.ack;
	assign wr_lo    = bus_req & wb_we_in & wb_sel_in[0];
	assign wr_hi    = bus_req & wb_we_in & wb_sel_in[1];
	assign rd_stat  = bus_req & ~wb_we_in & (wb_adr_in == `WWDT_OFS_STAT);

	// Closed part of the period, on the postscaler count
	always_comb begin
		unique case (q.cfg[`WWDT_CF_WIN_HI:`WWDT_CF_WIN_LO])
			2'h0: closed = period - (period >> 2);
			2'h1: closed = period - (period >> 2) - (period >> 3);
			2'h2: closed = period >> 1;
			2'h3: closed = period >> 2;
		endcase
	end

	// A clear on the terminal tick wins, so feeding just in time never causes a timeout reset
	assign timeout = enabled & osc_tick & (q.pre_cnt == pre_last) & (q.post_cnt == post_last) & ~clr_hit;
	assign clr_hit = wd_clear_instr_in & run;
	assign fault   = clr_hit & enabled & ~q.cfg[`WWDT_CF_WINDOW_DISABLE] & ({1'b0, q.post_cnt} < closed);
	assign dev_rst = sys_reset_in | (timeout & run) | fault;

	// ********************
	// Next state
	// ********************
	always_comb begin
		d = q;
		d.osc_s1 = low_power_rc_osc_in;
		d.osc_s2 = q.osc_s1;
		d.osc_s3 = q.osc_s2;
		d.rst_pulse  = 1'b0;
		d.wake_pulse = 1'b0;
		d.ack = bus_req;
		ev = 3'h0;
		zero_cnt = 1'b0;

		// Counts keep going in every power mode
		if (enabled && osc_tick) begin
			if (q.pre_cnt == pre_last) begin
				d.pre_cnt = 7'h00;
				d.post_cnt = (q.post_cnt == post_last) ? 16'h0000 : q.post_cnt + 16'h0001;
			end else begin
				d.pre_cnt = q.pre_cnt + 7'h01;
			end
		end

		// Bus read data, unmapped offsets read zero
		if (bus_req && !wb_we_in) begin
			unique case (wb_adr_in)
				`WWDT_OFS_RCTL: d.rdata = {26'h0, q.soft_en, q.to_flag, q.sleep_flag, q.idle_flag, 2'h0};
				`WWDT_OFS_CFG:  d.rdata = {22'h0, q.cfg};
				`WWDT_OFS_STAT: d.rdata = {29'h0, q.stat};
				`WWDT_OFS_MASK: d.rdata = {29'h0, q.mask};
				default:        d.rdata = 32'h0000_0000;
			endcase
		end

		// Bus writes come first so hardware sets below win
		if (wr_lo) begin
			unique case (wb_adr_in)
				`WWDT_OFS_RCTL: begin
					d.soft_en    = wb_dat_in[`WWDT_RC_SOFT_EN];
					d.to_flag    = wb_dat_in[`WWDT_RC_TIMEOUT];
					d.sleep_flag = wb_dat_in[`WWDT_RC_SLEEP];
					d.idle_flag  = wb_dat_in[`WWDT_RC_IDLE];
				end
				`WWDT_OFS_CFG:  d.cfg[7:0] = {wb_dat_in[7:6], 1'b0, wb_dat_in[4:0]};
				`WWDT_OFS_MASK: d.mask = wb_dat_in[`WWDT_ST_W-1:0];
				default: begin
				end
			endcase
		end
		if (wr_hi && wb_adr_in == `WWDT_OFS_CFG) begin
			d.cfg[9:8] = wb_dat_in[9:8];
		end

		if (clr_hit) begin
			zero_cnt = 1'b1;
		end
		if (clk_switch_done_in) begin
			zero_cnt = 1'b1;
		end

		// Power mode sequencing
		unique case (q.pm)
			WWDT_RUN: begin
				if (power_save_instr_in && !dev_rst) begin
					d.pm = power_save_idle_in ? WWDT_IDLE : WWDT_SLEEP;
					d.idle_flag  = d.idle_flag | power_save_idle_in;
					d.sleep_flag = d.sleep_flag | ~power_save_idle_in;
					zero_cnt = 1'b1;
				end
			end
			WWDT_SLEEP, WWDT_IDLE: begin
				if (timeout || wake_event_in) begin
					d.pm = WWDT_RUN;
					d.wake_pulse = 1'b1;
					zero_cnt = 1'b1;
					ev[`WWDT_ST_WAKE] = 1'b1;
				end
			end
			default: d.pm = WWDT_RUN;
		endcase

		if (timeout) begin
			d.to_flag = 1'b1;
			ev[`WWDT_ST_TIMEOUT] = 1'b1;
		end
		if (fault) begin
			ev[`WWDT_ST_FAULT] = 1'b1;
		end

		// A device reset outranks everything except the sticky flags
		if (dev_rst) begin
			d.rst_pulse = ~sys_reset_in;
			d.soft_en = 1'b0;
			d.pm = WWDT_RUN;
			d.wake_pulse = 1'b0;
			zero_cnt = 1'b1;
		end
		if (zero_cnt || !enabled) begin
			d.pre_cnt = 7'h00;
			d.post_cnt = 16'h0000;
		end

		// Read clears status, a same-cycle event survives
		d.stat = (rd_stat ? 3'h0 : q.stat) | ev;
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			q <= '0;
			q.cfg <= `WWDT_CF_RESET;
			q.pm <= WWDT_RUN;
		end else begin
			q <= d;
		end
	end

	// ********************
	// Outputs
	// ********************
	assign wb_dat_out = q.rdata;
	assign wb_ack_out = q.ack;
	assign irq_out = |(q.stat & q.mask);
	assign low_power_rc_osc_en_out = enabled;
	assign device_reset_out = q.rst_pulse;
	assign wake_out = q.wake_pulse;
	assign power_mode_out = q.pm;

	// ********************
	// Checks
	// ********************
	sequence s_run_timeout;
		timeout && run;
	endsequence

	sequence s_reset_done;
		device_reset_out && q.pre_cnt == 7'h00 && q.post_cnt == 16'h0000 && !q.soft_en;
	endsequence

	property p_osc_en;
		@(posedge clk_in) disable iff (!arst_n_in)
		$rose(q.soft_en) |-> low_power_rc_osc_en_out;
	endproperty
	a_osc_en: assert property (p_osc_en) else $error("oscillator not enabled");

	property p_pre_wrap;
		@(posedge clk_in) disable iff (!arst_n_in)
		enabled && osc_tick && q.pre_cnt == pre_last && !dev_rst && !zero_cnt |=> q.pre_cnt == 7'h00;
	endproperty
	a_pre_wrap: assert property (p_pre_wrap) else $error("prescaler wrap wrong");

	property p_post_step;
		@(posedge clk_in) disable iff (!arst_n_in)
		enabled && osc_tick && q.pre_cnt == pre_last && q.post_cnt != post_last && !zero_cnt && !dev_rst
		|=> q.post_cnt == $past(q.post_cnt) + 16'h0001;
	endproperty
	a_post_step: assert property (p_post_step) else $error("postscaler step wrong");

	property p_run_timeout;
		@(posedge clk_in) disable iff (!arst_n_in)
		s_run_timeout |=> s_reset_done ##1 !device_reset_out;
	endproperty
	a_run_timeout: assert property (p_run_timeout) else $error("timeout reset wrong");

	property p_clk_switch;
		@(posedge clk_in) disable iff (!arst_n_in)
		clk_switch_done_in |=> q.pre_cnt == 7'h00 && q.post_cnt == 16'h0000;
	endproperty
	a_clk_switch: assert property (p_clk_switch) else $error("clock switch clear missed");

	property p_sleep_entry;
		@(posedge clk_in) disable iff (!arst_n_in)
		run && power_save_instr_in && !dev_rst |=> !run && q.pre_cnt == 7'h00 && q.post_cnt == 16'h0000;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");

	property p_wake;
		@(posedge clk_in) disable iff (!arst_n_in)
		!run && timeout && !sys_reset_in |=> wake_out && run && q.to_flag && !device_reset_out;
	endproperty
	a_wake: assert property (p_wake) else $error("sleep timeout did not wake");

	property p_clear;
		@(posedge clk_in) disable iff (!arst_n_in)
		clr_hit && !fault |=> q.pre_cnt == 7'h00 && q.post_cnt == 16'h0000 && !device_reset_out;
	endproperty
	a_clear: assert property (p_clear) else $error("clear instruction ignored");

	property p_hard_en;
		@(posedge clk_in) disable iff (!arst_n_in)
		q.cfg[`WWDT_CF_HARD_EN] |-> enabled;
	endproperty
	a_hard_en: assert property (p_hard_en) else $error("hard enable not forcing");

	property p_soft_off;
		@(posedge clk_in) disable iff (!arst_n_in)
		!q.cfg[`WWDT_CF_HARD_EN] && !q.soft_en |=> q.pre_cnt == 7'h00;
	endproperty
	a_soft_off: assert property (p_soft_off) else $error("disabled watchdog counts");

	property p_flag_sticky;
		@(posedge clk_in) disable iff (!arst_n_in)
		q.to_flag && !wr_lo |=> q.to_flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("timeout flag lost");

	property p_window;
		@(posedge clk_in) disable iff (!arst_n_in)
		clr_hit && enabled && !q.cfg[`WWDT_CF_WINDOW_DISABLE] && {1'b0, q.post_cnt} < closed |=> device_reset_out;
	endproperty
	a_window: assert property (p_window) else $error("early clear not punished");

	property p_irq;
		@(posedge clk_in) disable iff (!arst_n_in)
		timeout && q.mask[`WWDT_ST_TIMEOUT] |=> irq_out;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");

	property p_fault_stat;
		@(posedge clk_in) disable iff (!arst_n_in)
		fault && !sys_reset_in |=> q.stat[`WWDT_ST_FAULT] && device_reset_out;
	endproperty
	a_fault_stat: assert property (p_fault_stat) else $error("window fault not flagged");

	property p_save_flag;
		@(posedge clk_in) disable iff (!arst_n_in)
		run && power_save_instr_in && !dev_rst |=> ($past(power_save_idle_in) ? q.idle_flag : q.sleep_flag);
	endproperty
	a_save_flag: assert property (p_save_flag) else $error("power save flag missing");

	property p_soft_clear;
		@(posedge clk_in) disable iff (!arst_n_in)
		dev_rst |=> !q.soft_en;
	endproperty
	a_soft_clear: assert property (p_soft_clear) else $error("soft enable survived reset");

	property p_wake_zero;
		@(posedge clk_in) disable iff (!arst_n_in)
		wake_out |-> q.pre_cnt == 7'h00 && q.post_cnt == 16'h0000;
	endproperty
	a_wake_zero: assert property (p_wake_zero) else $error("counts kept on wake");

	// Only sources that legally zero the counts are excluded
	property p_save_count;
		@(posedge clk_in) disable iff (!arst_n_in)
		!run && enabled && osc_tick && q.pre_cnt != pre_last
		&& !wake_event_in && !sys_reset_in && !clk_switch_done_in
		|=> q.pre_cnt == $past(q.pre_cnt) + 7'h01;
	endproperty
	a_save_count: assert property (p_save_count) else $error("counting stalled in power save");

	property p_stat_read;
		@(posedge clk_in) disable iff (!arst_n_in)
		rd_stat |=> q.stat == $past(ev);
	endproperty
	a_stat_read: assert property (p_stat_read) else $error("status read clear wrong");

endmodule
`default_nettype wire

// file: src/wwdt_params.svh
// Constants of the windowed watchdog: offsets, fields, reset values, counts.
// Included by the package and by the top; definitions only.
`ifndef WWDT_PARAMS_SVH
`define WWDT_PARAMS_SVH

// ********************
// Register offsets
// ********************
`define WWDT_OFS_RCTL     32'h0000_0000
`define WWDT_OFS_CFG      32'h0000_0004
`define WWDT_OFS_STAT     32'h0000_0008
`define WWDT_OFS_MASK     32'h0000_000C

// ********************
// Reset control fields
// ********************
`define WWDT_RC_SOFT_EN   5
`define WWDT_RC_TIMEOUT   4
`define WWDT_RC_SLEEP     3
`define WWDT_RC_IDLE      2

// ********************
// Config word fields
// ********************
`define WWDT_CF_POST_LO   0
`define WWDT_CF_POST_HI   3
`define WWDT_CF_PRE       4
`define WWDT_CF_WINDOW_DISABLE    6
`define WWDT_CF_HARD_EN   7
`define WWDT_CF_WIN_LO    8
`define WWDT_CF_WIN_HI    9
`define WWDT_CF_RESET     10'h0_0C0

// ********************
// Status and mask bits
// ********************
`define WWDT_ST_TIMEOUT   0
`define WWDT_ST_FAULT     1
`define WWDT_ST_WAKE      2
`define WWDT_ST_W         3

// ********************
// Counter limits
// ********************
`define WWDT_PRE_LAST5    7'h1F
`define WWDT_PRE_LAST7    7'h7F

`endif

// file: src/wwdt_pkg.sv
// Types of the windowed watchdog: power mode and the packed state record.
// Assumes the constant header sits beside it on the include path.
`include "wwdt_params.svh"

package wwdt_pkg;

	typedef enum logic [1:0] {
		WWDT_RUN,
		WWDT_SLEEP,
		WWDT_IDLE
	} wwdt_pm_t;

	typedef struct packed {
		logic              osc_s1;
		logic              osc_s2;
		logic              osc_s3;
		logic [6:0]        pre_cnt;
		logic [15:0]       post_cnt;
		logic              soft_en;
		logic              to_flag;
		logic              sleep_flag;
		logic              idle_flag;
		logic [9:0]        cfg;
		wwdt_pm_t          pm;
		logic [`WWDT_ST_W-1:0] stat;
		logic [`WWDT_ST_W-1:0] mask;
		logic              ack;
		logic [31:0]       rdata;
		logic              rst_pulse;
		logic              wake_pulse;
	} wwdt_state_t;

endpackage

// file: tb/wwdt_core_model.sv
// Model of the processor core: clear and power-save strobes.
// Assumes the watchdog samples each strobe on a clk_in rising edge.
`timescale 1ns/1ns
`default_nettype none

module wwdt_core_model (
	input  wire logic clk_in,
	output logic      clear_out,
	output logic      save_out,
	output logic      idle_out
);
	initial begin
		clear_out = 1'b0;
		save_out  = 1'b0;
		idle_out  = 1'b0;
	end

	// One-cycle strobes, as a single instruction gives
	task automatic clear_wd();
		@(posedge clk_in);
		clear_out <= 1'b1;
		@(posedge clk_in);
		clear_out <= 1'b0;
	endtask

	task automatic enter_save(input logic idle);
		@(posedge clk_in);
		save_out <= 1'b1;
		idle_out <= idle;
		@(posedge clk_in);
		save_out <= 1'b0;
		idle_out <= 1'b0;
	endtask
endmodule

`default_nettype wire

// file: tb/wwdt_top_test.sv
// Self-checking bench for the windowed watchdog.
// Assumes a fast RC pin (rising edge every 8 clk) and Wishbone at offsets of the header.
`timescale 1ns/1ns
`default_nettype none
`include "wwdt_params.svh"

module wwdt_top_test;
	import wwdt_pkg::*;
	localparam logic [31:0] rc_a = `WWDT_OFS_RCTL;
	localparam logic [31:0] cf_a = `WWDT_OFS_CFG;
	localparam logic [31:0] st_a = `WWDT_OFS_STAT;
	localparam logic [31:0] mk_a = `WWDT_OFS_MASK;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        rc = 1'b0;
	logic        sr = 1'b0;
	logic        sw = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [31:0] adr = 32'h0000_0000;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic [31:0] rd;
	logic        ack, irq, osc_en, dev_rst, wake, clr, sav, idl, r, w;
	wwdt_pm_t    pm;
	int          num_errors = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          n;
	logic [31:0] cfg_tab [3] = '{32'h0000_00C0, 32'h0000_00D0, 32'h0000_00C2};
	int          tick_tab [3] = '{32, 128, 128};

	wwdt_top i_wwdt_top (
		.clk_in                  (clk),
		.arst_n_in               (arst_n),
		.low_power_rc_osc_in     (rc),
		.wd_clear_instr_in       (clr),
		.power_save_instr_in     (sav),
		.power_save_idle_in      (idl),
		.wake_event_in           (1'b0),
		.clk_switch_done_in      (sw),
		.sys_reset_in            (sr),
		.wb_cyc_in               (cyc),
		.wb_stb_in               (stb),
		.wb_we_in                (we),
		.wb_adr_in               (adr),
		.wb_sel_in               (4'hF),
		.wb_dat_in               (wdat),
		.wb_dat_out              (rdat),
		.wb_ack_out              (ack),
		.irq_out                 (irq),
		.low_power_rc_osc_en_out (osc_en),
		.device_reset_out        (dev_rst),
		.wake_out                (wake),
		.power_mode_out          (pm)
	);

	wwdt_core_model i_wwdt_core_model (
		.clk_in    (clk),
		.clear_out (clr),
		.save_out  (sav),
		.idle_out  (idl)
	);

	initial forever #50 clk = ~clk;

	initial forever begin
		repeat (4) @(posedge clk);
		rc <= ~rc;
	end

	// ********************
	// Tasks
	// ********************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
		total_checks++;
		if (g < lo || g > hi) begin
			num_errors++;
			$display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
		end
	endtask

	// Waits for ack with no cycle limit; the bench timeout ends a hang
	task automatic wb(input logic w_en, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w_en;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	// Counts cycles to a reset or wake pulse; the RC phase is free, so callers allow slack
	task automatic wait_out(input int lim);
		n = 0;
		r = 1'b0;
		w = 1'b0;
		while (n < lim && r !== 1'b1 && w !== 1'b1) begin
			@(posedge clk);
			n++;
			r = dev_rst;
			w = wake;
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			summarize();
		end
	end

	// ********************
	// Sequence
	// ********************
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		wb(0, cf_a, 0);
		chk("cfg", 32'h0000_00C0, rd);
		chk("osc_en", 1, osc_en);
		wb(0, rc_a, 0);
		chk("rctl", 0, rd);
		wb(0, 32'h0000_0040, 0);
		chk("unmapped", 0, rd);
		wb(1, mk_a, 1);
		for (int i = 0; i < 3; i++) begin
			wb(1, cf_a, cfg_tab[i]);
			i_wwdt_core_model.clear_wd();
			wait_out(2000);
			chk_rng("period", tick_tab[i] * 8 - 24, tick_tab[i] * 8 + 24, n);
			@(posedge clk);
			chk("irq", 1, irq);
			wb(0, st_a, 0);
			chk("stat", 1, rd);
		end
		@(posedge clk);
		chk("irq_clr", 0, irq);
		wb(0, rc_a, 0);
		chk("to_flag", 32'h0000_0010, rd);
		wb(1, rc_a, 0);
		wb(1, mk_a, 0);
		wb(1, cf_a, 32'h0000_00C0);
		i_wwdt_core_model.clear_wd();
		repeat (3) begin
			repeat (120) @(posedge clk);
			i_wwdt_core_model.clear_wd();
		end
		wait_out(150);
		chk("fed", 0, r);
		wait_out(400);
		@(posedge clk);
		chk("irq_mask", 0, irq);
		wb(1, cf_a, 32'h0000_0082);
		i_wwdt_core_model.clear_wd();
		wait_out(4);
		chk("early", 1, r);
		wb(0, st_a, 0);
		chk("fault", 32'h0000_0002, rd & 32'h0000_0002);
		repeat (850) @(posedge clk);
		i_wwdt_core_model.clear_wd();
		wait_out(100);
		chk("late", 0, r);
		wb(1, cf_a, 32'h0000_00C0);
		wb(1, rc_a, 0);
		for (int k = 0; k < 2; k++) begin
			i_wwdt_core_model.clear_wd();
			repeat (100) @(posedge clk);
			i_wwdt_core_model.enter_save(k[0]);
			@(posedge clk);
			chk("pm", k ? 32'(WWDT_IDLE) : 32'(WWDT_SLEEP), 32'(pm));
			wait_out(400);
			chk_rng("save_to", 232, 280, n);
			chk("wake", 1, w);
			chk("no_rst", 0, r);
			wb(0, rc_a, 0);
			chk("rctl_s", k ? 32'h0000_0014 : 32'h0000_0018, rd);
			chk("pm_run", 32'(WWDT_RUN), 32'(pm));
			wb(1, rc_a, 0);
			wait_out(400);
			chk_rng("exit", 220, 272, n);
		end
		wb(1, cf_a, 32'h0000_0040);
		chk("osc_off", 0, osc_en);
		wait_out(600);
		chk("off", 0, r);
		wb(1, rc_a, 32'h0000_0020);
		chk("osc_on", 1, osc_en);
		i_wwdt_core_model.clear_wd();
		wait_out(400);
		chk_rng("soft", 232, 280, n);
		wb(1, rc_a, 32'h0000_0020);
		@(posedge clk);
		sr <= 1'b1;
		@(posedge clk);
		sr <= 1'b0;
		wb(0, rc_a, 0);
		chk("soft_clr", 0, rd & 32'h0000_0020);
		wb(1, cf_a, 32'h0000_00C0);
		for (int k = 0; k < 2; k++) begin
			i_wwdt_core_model.clear_wd();
			repeat (150) @(posedge clk);
			if (k == 1) begin
				sw <= 1'b1;
			end else begin
				sr <= 1'b1;
			end
			@(posedge clk);
			sw <= 1'b0;
			sr <= 1'b0;
			wait_out(400);
			chk_rng("restart", 232, 280, n);
		end
		summarize();
	end
endmodule

`default_nettype wire
